// ==== rtl/lpm_regs.svh ====
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH
// register port geometry
`define LPM_ADDR_W 2
`define LPM_DATA_W 8
`define LPM_OFS_CTRL_ONE 2'h0
`define LPM_OFS_CTRL_TWO 2'h1
`define LPM_OFS_TIMER_A_MODE 2'h2
`define LPM_OFS_STATUS 2'h3
// power_control_reg_one fields
`define LPM_C1_STANDBY_BIT 7
`define LPM_C1_SETTLE_HI 6
`define LPM_C1_SETTLE_LO 4
`define LPM_C1_LOW_SPEED_BIT 3
`define LPM_C1_RSVD_BIT 2
`define LPM_C1_MEDDIV_HI 1
`define LPM_C1_MEDDIV_LO 0
`define LPM_C1_RESET 8'h07
// power_control_reg_two fields
`define LPM_C2_RSVD_MASK 8'he0
`define LPM_C2_NOISE_BIT 4
`define LPM_C2_DIRECT_BIT 3
`define LPM_C2_MEDIUM_BIT 2
`define LPM_C2_SUBDIV_HI 1
`define LPM_C2_SUBDIV_LO 0
`define LPM_C2_RESET 8'he0
// timer_a_mode_reg field held here
`define LPM_TA_WATCH_CLK_BIT 3
`define LPM_TA_RESET 8'h00
// settling wait in states (clock cycles)
`define LPM_SETTLE_CNT_W 17
`define LPM_SETTLE_STATES_0 8192
`define LPM_SETTLE_STATES_1 16384
`define LPM_SETTLE_STATES_2 32768
`define LPM_SETTLE_STATES_3 65536
`define LPM_SETTLE_STATES_4 131072
// interrupt sources: 0 timer A, 1 timer B1, 2 timer X, 3 timer V, 4 ext 0, 5 ext 1,
// 6 ext 2..3, 7 key lines, 8 serial three, 9 serial one, 10 analog converter
`define LPM_IRQ_N 11
`define LPM_WAKE_SLEEP 11'h7ff
`define LPM_WAKE_STANDBY 11'h030
`define LPM_WAKE_WATCH 11'h011
`endif

// ==== rtl/lpm_pkg.sv ====
`include "lpm_regs.svh"
package lpm_pkg;
  typedef enum logic [3:0] {
    LPM_ACTIVE_HS, LPM_ACTIVE_MS, LPM_SUBACTIVE, LPM_SLEEP_HS, LPM_SLEEP_MS,
    LPM_STANDBY, LPM_WATCH, LPM_SETTLE, LPM_RESET_HOLD
  } lpm_state_type;
  typedef struct packed {
    logic cpu_halt;
    logic osc_run;
    logic clock_dist_en;
    logic periph_clk_en;
    logic pwm_clk_en;
    logic timer_a_clk_en;
    logic io_hiz;
    logic io_hold;
    logic medium_clk_sel;
    logic sub_clk_sel;
  } lpm_out_type;
  typedef struct packed {
    lpm_state_type state;
    logic standby_select;
    logic [2:0] settling_wait_field;
    logic low_speed_select;
    logic [1:0] medium_div;
    logic noise_sel;
    logic direct_transfer_select;
    logic medium_speed_select;
    logic [1:0] sub_div;
    logic watch_clock_select;
    logic target_ms;
    logic settle_start;
    logic irq_exc;
    logic rst_exc;
    logic [`LPM_DATA_W-1:0] rdata;
    lpm_out_type outs;
  } lpm_ctrl_type;
  typedef struct packed {
    logic busy;
    logic done;
    logic [`LPM_SETTLE_CNT_W-1:0] cnt;
  } lpm_timer_type;
  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
  } lpm_qual_type;
endpackage

// ==== rtl/lpm_settle_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lpm_regs.svh"
module lpm_settle_timer
#(
  parameter int STATES_0 = `LPM_SETTLE_STATES_0,
  parameter int STATES_1 = `LPM_SETTLE_STATES_1,
  parameter int STATES_2 = `LPM_SETTLE_STATES_2,
  parameter int STATES_3 = `LPM_SETTLE_STATES_3,
  parameter int STATES_4 = `LPM_SETTLE_STATES_4
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [2:0] code,
  output logic busy,
  output logic done
);
  import lpm_pkg::*;
  lpm_timer_type t_reg;
  lpm_timer_type t_next;
  // load value is the wait minus one so the count spans the wait and the done pulse follows the last state
  always_comb
  begin
    t_next = t_reg;
    t_next.done = 1'b0;
    if (start)
    begin
      t_next.busy = 1'b1;
      if (code[2])
        t_next.cnt = `LPM_SETTLE_CNT_W'(STATES_4 - 1);
      else
        case (code[1:0])
          2'h0: t_next.cnt = `LPM_SETTLE_CNT_W'(STATES_0 - 1);
          2'h1: t_next.cnt = `LPM_SETTLE_CNT_W'(STATES_1 - 1);
          2'h2: t_next.cnt = `LPM_SETTLE_CNT_W'(STATES_2 - 1);
          default: t_next.cnt = `LPM_SETTLE_CNT_W'(STATES_3 - 1);
        endcase
    end
    else if (t_reg.busy)
    begin
      if (t_reg.cnt == '0)
      begin
        t_next.busy = 1'b0;
        t_next.done = 1'b1;
      end
      else
        t_next.cnt = t_reg.cnt - 1'b1;
    end
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      t_reg <= '0;
    else
      t_reg <= t_next;
  end
  assign busy = t_reg.busy;
  assign done = t_reg.done;
endmodule
`default_nettype wire

// ==== rtl/lpm_wake_qual.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lpm_regs.svh"
module lpm_wake_qual
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic irq_global_mask,
  input wire logic [`LPM_IRQ_N-1:0] irq_request,
  input wire logic [`LPM_IRQ_N-1:0] irq_enable,
  input wire logic [`LPM_IRQ_N-1:0] wake_allow,
  output logic pin_low,
  output logic pin_release,
  output logic wake
);
  import lpm_pkg::*;
  lpm_qual_type q_reg;
  lpm_qual_type q_next;
  logic [`LPM_IRQ_N-1:0] qualified;
  // two-stage synchroniser on the pin; the second stage and a third flop behind it (for the release edge) are looked at
  always_comb
  begin
    q_next = q_reg;
    q_next.pin_meta = ~reset_pin_n;
    q_next.pin_sync = q_reg.pin_meta;
    q_next.pin_prev = q_reg.pin_sync;
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end
  // per-source qualification against its enable and the mode's wake set
  genvar i;
  generate
    for (i = 0; i < `LPM_IRQ_N; i++)
    begin : g_src
      assign qualified[i] = irq_request[i] & irq_enable[i] & wake_allow[i];
    end
  endgenerate
  assign wake = (|qualified) & ~irq_global_mask;
  assign pin_low = q_reg.pin_sync;
  assign pin_release = q_reg.pin_prev & ~q_reg.pin_sync;
endmodule
`default_nettype wire

// ==== rtl/lpm_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lpm_regs.svh"
module lpm_ctrl
#(
  parameter int SETTLE_STATES_0 = `LPM_SETTLE_STATES_0,
  parameter int SETTLE_STATES_1 = `LPM_SETTLE_STATES_1,
  parameter int SETTLE_STATES_2 = `LPM_SETTLE_STATES_2,
  parameter int SETTLE_STATES_3 = `LPM_SETTLE_STATES_3,
  parameter int SETTLE_STATES_4 = `LPM_SETTLE_STATES_4
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic halt_strobe,
  input wire logic irq_global_mask,
  input wire logic [`LPM_IRQ_N-1:0] irq_request,
  input wire logic [`LPM_IRQ_N-1:0] irq_enable,
  input wire logic [`LPM_ADDR_W-1:0] reg_addr,
  input wire logic [`LPM_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`LPM_DATA_W-1:0] reg_rdata,
  output logic [3:0] power_state,
  output logic cpu_halt,
  output logic cpu_reset,
  output logic reset_exc_start,
  output logic irq_exc_start,
  output logic osc_run,
  output logic clock_dist_en,
  output logic periph_clk_en,
  output logic pwm_clk_en,
  output logic timer_a_clk_en,
  output logic io_hiz,
  output logic io_hold,
  output logic medium_clk_sel,
  output logic [1:0] medium_div_sel,
  output logic sub_clk_sel,
  output logic settle_busy
);
  import lpm_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  lpm_ctrl_type c_reg;
  lpm_ctrl_type c_next;
  logic [`LPM_IRQ_N-1:0] wake_allow;
  logic pin_low;
  logic pin_release;
  logic wake;
  logic settle_done;
  logic [`LPM_DATA_W-1:0] rd_one;
  logic [`LPM_DATA_W-1:0] rd_two;
  logic [`LPM_DATA_W-1:0] rd_ta;
  logic [`LPM_DATA_W-1:0] rd_status;

  // ----------------------------------------------------------------
  // output decode per power state
  // ----------------------------------------------------------------
  // outputs are decoded from the next state and registered, so they change
  // in the same edge as power_state and never glitch toward the clock tree
  function automatic lpm_out_type decode_outs(input lpm_state_type s);
    lpm_out_type o;
    o = '0;
    case (s)
      LPM_ACTIVE_HS, LPM_ACTIVE_MS, LPM_SUBACTIVE:
      begin
        o.osc_run = (s != LPM_SUBACTIVE);
        o.clock_dist_en = 1'b1;
        o.periph_clk_en = 1'b1;
        o.pwm_clk_en = 1'b1;
        o.timer_a_clk_en = 1'b1;
        o.medium_clk_sel = (s == LPM_ACTIVE_MS);
        o.sub_clk_sel = (s == LPM_SUBACTIVE);
      end
      LPM_SLEEP_HS, LPM_SLEEP_MS:
      begin
        o.cpu_halt = 1'b1;
        o.osc_run = 1'b1;
        o.clock_dist_en = 1'b1;
        o.periph_clk_en = 1'b1;
        o.timer_a_clk_en = 1'b1;
        o.medium_clk_sel = (s == LPM_SLEEP_MS);
      end
      LPM_STANDBY:
      begin
        o.cpu_halt = 1'b1;
        o.io_hiz = 1'b1;
      end
      LPM_SETTLE:
      begin
        // oscillator running but not yet handed to the chip; ports float, also
        // when coming from watch, because standby or watch is not cleared until the end
        o.cpu_halt = 1'b1;
        o.osc_run = 1'b1;
        o.io_hiz = 1'b1;
      end
      LPM_WATCH:
      begin
        o.cpu_halt = 1'b1;
        o.timer_a_clk_en = 1'b1;
        o.io_hold = 1'b1;
      end
      LPM_RESET_HOLD:
      begin
        // clock reaches the whole chip at once; a short reset pulse would
        // therefore run logic on an unsettled oscillator
        o.osc_run = 1'b1;
        o.clock_dist_en = 1'b1;
        o.periph_clk_en = 1'b1;
        o.pwm_clk_en = 1'b1;
        o.timer_a_clk_en = 1'b1;
      end
      default:
      begin
        o.osc_run = 1'b1;
        o.clock_dist_en = 1'b1;
      end
    endcase
    return o;
  endfunction

  // ----------------------------------------------------------------
  // wake source set for the present mode
  // ----------------------------------------------------------------
  always_comb
  begin
    case (c_reg.state)
      LPM_SLEEP_HS, LPM_SLEEP_MS: wake_allow = `LPM_WAKE_SLEEP;
      LPM_STANDBY: wake_allow = `LPM_WAKE_STANDBY;
      LPM_WATCH: wake_allow = `LPM_WAKE_WATCH;
      default: wake_allow = '0;
    endcase
  end

  lpm_wake_qual u_wake
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .reset_pin_n(reset_pin_n),
    .irq_global_mask(irq_global_mask),
    .irq_request(irq_request),
    .irq_enable(irq_enable),
    .wake_allow(wake_allow),
    .pin_low(pin_low),
    .pin_release(pin_release),
    .wake(wake)
  );

  lpm_settle_timer
  #(
    .STATES_0(SETTLE_STATES_0),
    .STATES_1(SETTLE_STATES_1),
    .STATES_2(SETTLE_STATES_2),
    .STATES_3(SETTLE_STATES_3),
    .STATES_4(SETTLE_STATES_4)
  )
  u_settle
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(c_reg.settle_start),
    .code(c_reg.settling_wait_field),
    .busy(settle_busy),
    .done(settle_done)
  );

  // ----------------------------------------------------------------
  // register read images
  // ----------------------------------------------------------------
  // reserved bits read as in the reset image of each register: ones in both power control registers, zeros in timer_a_mode_reg
  assign rd_one = {c_reg.standby_select, c_reg.settling_wait_field, c_reg.low_speed_select,
                   1'b1, c_reg.medium_div};
  assign rd_two = `LPM_C2_RSVD_MASK | {3'h0, c_reg.noise_sel, c_reg.direct_transfer_select,
                   c_reg.medium_speed_select, c_reg.sub_div};
  assign rd_ta = {4'h0, c_reg.watch_clock_select, 3'h0};
  assign rd_status = {4'h0, c_reg.state};

  // ----------------------------------------------------------------
  // next state: registers, power mode, pulses
  // ----------------------------------------------------------------
  always_comb
  begin
    c_next = c_reg;
    c_next.settle_start = 1'b0;
    c_next.irq_exc = 1'b0;
    c_next.rst_exc = 1'b0;
    c_next.rdata = '0;

    // register reads: data stand one cycle after the strobe only
    if (reg_rd)
      case (reg_addr)
        `LPM_OFS_CTRL_ONE: c_next.rdata = rd_one;
        `LPM_OFS_CTRL_TWO: c_next.rdata = rd_two;
        `LPM_OFS_TIMER_A_MODE: c_next.rdata = rd_ta;
        default: c_next.rdata = rd_status;
      endcase

    // register writes; the status word is read-only
    if (reg_wr)
      case (reg_addr)
        `LPM_OFS_CTRL_ONE:
        begin
          c_next.standby_select = reg_wdata[`LPM_C1_STANDBY_BIT];
          c_next.settling_wait_field = reg_wdata[`LPM_C1_SETTLE_HI:`LPM_C1_SETTLE_LO];
          c_next.low_speed_select = reg_wdata[`LPM_C1_LOW_SPEED_BIT];
          c_next.medium_div = reg_wdata[`LPM_C1_MEDDIV_HI:`LPM_C1_MEDDIV_LO];
        end
        `LPM_OFS_CTRL_TWO:
        begin
          c_next.noise_sel = reg_wdata[`LPM_C2_NOISE_BIT];
          c_next.direct_transfer_select = reg_wdata[`LPM_C2_DIRECT_BIT];
          c_next.medium_speed_select = reg_wdata[`LPM_C2_MEDIUM_BIT];
          c_next.sub_div = reg_wdata[`LPM_C2_SUBDIV_HI:`LPM_C2_SUBDIV_LO];
        end
        `LPM_OFS_TIMER_A_MODE:
          c_next.watch_clock_select = reg_wdata[`LPM_TA_WATCH_CLK_BIT];
        default:
          c_next.rdata = c_next.rdata;
      endcase

    // power mode sequencing; the pin outranks every other event
    if (pin_low)
    begin
      // the pin resets the control registers too, like any reset source
      c_next.state = LPM_RESET_HOLD;
      c_next.standby_select = 1'b0;
      c_next.settling_wait_field = 3'h0;
      c_next.low_speed_select = 1'b0;
      c_next.medium_div = 2'(`LPM_C1_RESET >> `LPM_C1_MEDDIV_LO);
      c_next.noise_sel = 1'b0;
      c_next.direct_transfer_select = 1'b0;
      c_next.medium_speed_select = 1'b0;
      c_next.sub_div = 2'h0;
      c_next.watch_clock_select = 1'b0;
    end
    else
      case (c_reg.state)
        LPM_ACTIVE_HS, LPM_ACTIVE_MS:
        begin
          if (halt_strobe)
          begin
            if (c_reg.standby_select && c_reg.watch_clock_select)
              c_next.state = LPM_WATCH;
            else if (c_reg.standby_select && !c_reg.low_speed_select)
              c_next.state = LPM_STANDBY;
            else if (!c_reg.standby_select && !c_reg.low_speed_select &&
                     !c_reg.direct_transfer_select)
              c_next.state = c_reg.medium_speed_select ? LPM_SLEEP_MS : LPM_SLEEP_HS;
          end
        end
        LPM_SUBACTIVE:
        begin
          // only the watch entry is handled from the subclock mode
          if (halt_strobe && c_reg.standby_select && c_reg.watch_clock_select)
            c_next.state = LPM_WATCH;
        end
        LPM_SLEEP_HS, LPM_SLEEP_MS:
        begin
          // speed is the one slept at, not the select as it reads now
          if (wake)
          begin
            c_next.state = (c_reg.state == LPM_SLEEP_MS) ? LPM_ACTIVE_MS : LPM_ACTIVE_HS;
            c_next.irq_exc = 1'b1;
          end
        end
        LPM_STANDBY:
        begin
          if (wake)
          begin
            c_next.state = LPM_SETTLE;
            c_next.settle_start = 1'b1;
            c_next.target_ms = c_reg.medium_speed_select;
          end
        end
        LPM_WATCH:
        begin
          if (wake)
          begin
            if (c_reg.low_speed_select)
            begin
              // subclock keeps running in watch, so no settling is needed
              c_next.state = LPM_SUBACTIVE;
              c_next.irq_exc = 1'b1;
            end
            else
            begin
              c_next.state = LPM_SETTLE;
              c_next.settle_start = 1'b1;
              c_next.target_ms = c_reg.medium_speed_select;
            end
          end
        end
        LPM_SETTLE:
        begin
          if (settle_done)
          begin
            c_next.state = c_reg.target_ms ? LPM_ACTIVE_MS : LPM_ACTIVE_HS;
            c_next.irq_exc = 1'b1;
          end
        end
        LPM_RESET_HOLD:
        begin
          if (pin_release)
          begin
            c_next.state = LPM_ACTIVE_HS;
            c_next.rst_exc = 1'b1;
          end
        end
        default:
          c_next.state = LPM_ACTIVE_HS;
      endcase

    c_next.outs = decode_outs(c_next.state);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      c_reg <= '0;
      c_reg.state <= LPM_ACTIVE_HS;
      c_reg.medium_div <= 2'h3;
      c_reg.outs.osc_run <= 1'b1;
      c_reg.outs.clock_dist_en <= 1'b1;
      c_reg.outs.periph_clk_en <= 1'b1;
      c_reg.outs.pwm_clk_en <= 1'b1;
      c_reg.outs.timer_a_clk_en <= 1'b1;
    end
    else
      c_reg <= c_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = c_reg.rdata;
  assign power_state = c_reg.state;
  assign cpu_halt = c_reg.outs.cpu_halt;
  assign cpu_reset = (c_reg.state == LPM_RESET_HOLD);
  assign reset_exc_start = c_reg.rst_exc;
  assign irq_exc_start = c_reg.irq_exc;
  assign osc_run = c_reg.outs.osc_run;
  assign clock_dist_en = c_reg.outs.clock_dist_en;
  assign periph_clk_en = c_reg.outs.periph_clk_en;
  assign pwm_clk_en = c_reg.outs.pwm_clk_en;
  assign timer_a_clk_en = c_reg.outs.timer_a_clk_en;
  assign io_hiz = c_reg.outs.io_hiz;
  assign io_hold = c_reg.outs.io_hold;
  assign medium_clk_sel = c_reg.outs.medium_clk_sel;
  assign medium_div_sel = c_reg.medium_div;
  assign sub_clk_sel = c_reg.outs.sub_clk_sel;
endmodule
`default_nettype wire

// ==== verif/lpm_ctrl_props.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lpm_regs.svh"
// -----------------------
// power mode checker
// -----------------------
module lpm_ctrl_props
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic halt_strobe,
  input wire logic irq_global_mask,
  input wire logic [`LPM_IRQ_N-1:0] irq_request,
  input wire logic [`LPM_IRQ_N-1:0] irq_enable,
  input wire logic [3:0] power_state,
  input wire logic cpu_halt,
  input wire logic cpu_reset,
  input wire logic reset_exc_start,
  input wire logic irq_exc_start,
  input wire logic osc_run,
  input wire logic clock_dist_en,
  input wire logic periph_clk_en,
  input wire logic pwm_clk_en,
  input wire logic timer_a_clk_en,
  input wire logic io_hiz,
  input wire logic io_hold
);
  import lpm_pkg::*;
  logic [2:0] pin_hist;
  logic pin_ok;
  logic [`LPM_IRQ_N-1:0] pend;
  // wakes are judged only once the pin has stayed high past its synchroniser
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      pin_hist <= 3'h7;
    else
      pin_hist <= {pin_hist[1:0], reset_pin_n};
  assign pin_ok = reset_pin_n & (&pin_hist);
  assign pend = irq_request & irq_enable & {`LPM_IRQ_N{~irq_global_mask}};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_sleep_outputs: assert property (
    power_state inside {LPM_SLEEP_HS, LPM_SLEEP_MS} |-> cpu_halt && periph_clk_en && !pwm_clk_en)
    else $error("sleep outputs wrong");
  a_standby_outputs: assert property (
    power_state == LPM_STANDBY |-> cpu_halt && !osc_run && !periph_clk_en && !timer_a_clk_en && io_hiz)
    else $error("standby outputs wrong");
  a_watch_outputs: assert property (
    power_state == LPM_WATCH |-> cpu_halt && timer_a_clk_en && !periph_clk_en && io_hold && !io_hiz)
    else $error("watch outputs wrong");
  a_mask_holds: assert property (
    power_state inside {[3:6]} && irq_global_mask && pin_ok |=> $stable(power_state))
    else $error("masked wake taken");
  a_sleep_wake: assert property (
    power_state inside {3, 4} && (|pend) && pin_ok |=> power_state == $past(power_state) - 4'h3 && irq_exc_start)
    else $error("sleep wake wrong");
  a_standby_wake: assert property (
    power_state == LPM_STANDBY && (|pend[5:4]) && pin_ok |=> power_state == LPM_SETTLE && osc_run)
    else $error("standby wake wrong");
  a_standby_deaf: assert property (
    power_state == LPM_STANDBY && !(|pend[5:4]) && pin_ok |=> power_state == LPM_STANDBY)
    else $error("standby left without cause");
  a_watch_wake: assert property (
    power_state == LPM_WATCH && (pend[0] || pend[4]) && pin_ok |=> power_state inside {2, 7})
    else $error("watch wake wrong");
  a_watch_deaf: assert property (
    power_state == LPM_WATCH && !pend[0] && !pend[4] && pin_ok |=> power_state == LPM_WATCH)
    else $error("watch left without cause");
  a_pin_resets: assert property (
    !reset_pin_n [*5] |-> power_state == LPM_RESET_HOLD && cpu_reset && osc_run && clock_dist_en)
    else $error("reset pin not obeyed");
  a_reset_exit: assert property (
    $rose(reset_exc_start) |-> $past(power_state) == LPM_RESET_HOLD && power_state == LPM_ACTIVE_HS)
    else $error("reset exit wrong");
  a_active_idle: assert property (
    power_state inside {[0:2]} && !halt_strobe && pin_ok |=> $stable(power_state))
    else $error("state moved without cause");
  c_sleep_wake: cover property (power_state == LPM_SLEEP_MS ##1 irq_exc_start);
  c_settle_done: cover property (power_state == LPM_SETTLE ##1 irq_exc_start);
  c_reset_exit: cover property (reset_exc_start);
endmodule
`default_nettype wire

// ==== verif/lpm_cpu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lpm_regs.svh"
// -----------------------
// cpu and interrupt side
// -----------------------
module lpm_cpu_model
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`LPM_IRQ_N-1:0] raise,
  input wire logic pin_cmd,
  input wire logic irq_exc_start,
  input wire logic osc_run,
  output logic [`LPM_IRQ_N-1:0] irq_request,
  output logic reset_pin_n
);
  logic [3:0] osc_cnt;
  // requests stay pending until the exception takes them; pin waits for a settled oscillator
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      irq_request <= '0;
      reset_pin_n <= 1'b1;
      osc_cnt <= 4'h0;
    end
    else
    begin
      irq_request <= irq_exc_start ? raise : (irq_request | raise);
      osc_cnt <= !osc_run ? 4'h0 : (osc_cnt == 4'hf ? osc_cnt : osc_cnt + 4'h1);
      reset_pin_n <= reset_pin_n ? !pin_cmd : (!pin_cmd && osc_cnt == 4'hf);
    end
endmodule
`default_nettype wire

// ==== verif/low_power_mode_controller_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lpm_regs.svh"
module low_power_mode_controller_bench;
  logic clk = 0, sys_rst = 1, halt_strobe = 0, irq_global_mask = 0, reg_wr = 0, reg_rd = 0, pin_cmd = 0;
  logic [10:0] irq_enable = '0, raise = '0, irq_request;
  logic [1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata;
  logic [3:0] power_state;
  logic irq_exc_start, reset_exc_start, osc_run, medium_clk_sel, sub_clk_sel, reset_pin_n;
  logic [1:0] medium_div_sel;
  int fail_count = 0, comparisons = 0, cycles = 0;
  // -----------------------
  // clock, parts, watchdog
  // -----------------------
  always #12.5 clk = ~clk;
  lpm_ctrl #(4, 5, 6, 7, 8) dut (.clk, .sys_rst, .reset_pin_n, .halt_strobe, .irq_global_mask, .irq_request,
    .irq_enable, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_state, .cpu_halt(), .cpu_reset(),
    .reset_exc_start, .irq_exc_start, .osc_run, .clock_dist_en(), .periph_clk_en(), .pwm_clk_en(),
    .timer_a_clk_en(), .io_hiz(), .io_hold(), .medium_clk_sel, .medium_div_sel, .sub_clk_sel, .settle_busy());
  lpm_cpu_model cpu (.clk, .sys_rst, .raise, .pin_cmd, .irq_exc_start, .osc_run, .irq_request, .reset_pin_n);
  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // -----------------------
  // drivers, all start just after an edge
  // -----------------------
  task automatic go(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // idle edge so a following write never reassigns the strobe in this step
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    @(posedge clk);
  endtask
  task automatic pulse(input logic h, input logic [10:0] src);
    halt_strobe <= h;
    raise <= src;
    @(posedge clk);
    halt_strobe <= 1'b0;
    raise <= '0;
  endtask
  task automatic see(input logic [3:0] s);
    #1;
    chk({4'h0, power_state}, {4'h0, s});
    @(posedge clk);
  endtask
  // counts settle cycles up to the exception pulse, pre-edge values
  task automatic wake(input logic [10:0] src, input logic [7:0] n, input logic [3:0] fin);
    logic [7:0] k;
    k = 8'h0;
    raise <= src;
    repeat (300)
    begin
      @(posedge clk);
      raise <= '0;
      if (power_state === 4'h7)
        k = k + 8'h1;
      if (irq_exc_start === 1'b1)
        break;
    end
    chk(k, n);
    chk({4'h0, power_state}, {4'h0, fin});
  endtask
  // -----------------------
  // scenarios
  // -----------------------
  task automatic t_regs;
    rd(0, 8'h07);
    rd(1, 8'he0);
    rd(2, 8'h00);
    wr(1, 8'h1f);
    rd(1, 8'hff);
    wr(0, 8'h00);
    rd(0, 8'h04);
    chk({6'h0, medium_div_sel}, 8'h00);
    wr(3, 8'hff);
    rd(3, 8'h00);
    wr(1, 8'he0);
  endtask
  task automatic t_refuse;
    wr(1, 8'he8);
    pulse(1, 0);
    see(0);
    wr(1, 8'he0);
    wr(0, 8'h0f);
    pulse(1, 0);
    see(0);
  endtask
  task automatic t_sleep;
    for (int m = 0; m < 2; m++)
    begin
      wr(0, 8'h07);
      wr(1, m ? 8'he4 : 8'he0);
      irq_enable <= 11'h6ff;
      pulse(1, 0);
      see(4'h3 + m[3:0]);
      chk(medium_clk_sel, m[7:0]);
      pulse(0, 11'h100);
      go(4);
      see(4'h3 + m[3:0]);
      irq_enable <= 11'h7ff;
      irq_global_mask <= 1'b1;
      go(4);
      see(4'h3 + m[3:0]);
      irq_global_mask <= 1'b0;
      wake(0, 0, m[3:0]);
    end
  endtask
  task automatic t_standby;
    logic [2:0] c;
    for (int i = 0; i < 6; i++)
    begin
      c = (i == 5) ? 3'h6 : i[2:0];
      wr(0, 8'h87 | {1'b0, c, 4'h0});
      wr(1, c[0] ? 8'he4 : 8'he0);
      pulse(1, 0);
      see(5);
      pulse(0, 11'h100);
      go(4);
      see(5);
      // settle state spans the start cycle, the n counted states and the done cycle
      wake(11'h010 << c[0], (c[2] ? 8'h8 : 8'h4 + c[1:0]) + 8'h2, {3'h0, c[0]});
    end
  endtask
  task automatic t_watch;
    wr(2, 8'h08);
    for (int f = 2; f >= 0; f--)
    begin
      wr(0, f[1] ? 8'h8f : 8'h87);
      wr(1, f[0] ? 8'he4 : 8'he0);
      pulse(1, 0);
      see(6);
      pulse(0, 11'h020);
      go(4);
      see(6);
      wake(f[0] ? 11'h001 : 11'h010, f[1] ? 8'h0 : 8'h6, f[3:0]);
      chk({7'h0, sub_clk_sel}, {7'h0, f[1]});
    end
  endtask
  task automatic t_pin;
    for (int i = 0; i < 3; i++)
    begin
      wr(0, i ? 8'h87 : 8'h07);
      wr(2, i == 2 ? 8'h08 : 8'h00);
      pulse(1, 0);
      see(4'h3 + i[3:0] + (i > 0));
      pin_cmd <= 1'b1;
      go(8);
      see(8);
      chk({7'h0, osc_run}, 8'h01);
      pin_cmd <= 1'b0;
      repeat (40)
      begin
        @(posedge clk);
        if (reset_exc_start === 1'b1)
          break;
      end
      chk({7'h0, reset_exc_start}, 8'h01);
      chk({4'h0, power_state}, 8'h00);
      rd(0, 8'h07);
    end
  endtask
  // main sequence
  initial
  begin
    go(4);
    sys_rst <= 1'b0;
    go(1);
    t_regs;
    t_refuse;
    t_sleep;
    t_standby;
    t_watch;
    t_pin;
    tally_and_finish;
  end
endmodule
bind lpm_ctrl lpm_ctrl_props props (.clk, .sys_rst, .reset_pin_n, .halt_strobe, .irq_global_mask, .irq_request,
  .irq_enable, .power_state, .cpu_halt, .cpu_reset, .reset_exc_start, .irq_exc_start, .osc_run, .clock_dist_en,
  .periph_clk_en, .pwm_clk_en, .timer_a_clk_en, .io_hiz, .io_hold);
`default_nettype wire
